// file: hw/oss_source_select.v
// Function
// - pick clock source from group and mode
// - decode group codes; mode for primary, and for pin function in every group
// - decode eleven primary modes from mode field
// - set second osc pin function per mode
// - first osc pin never general I/O
// - ten-bit timer releases after 1024 cycles
// - restart timer on reset and wake
// - delay only for crystal sources
// - low-power crystal runs while enable set
// - low-power crystal clocks only group 00
// - re-apply delay returning from low-power crystal to primary crystal
// - PLL multiplies primary only, x4/x8/x16
// - lock follows PLL phase lock
// - lock bit read only mirror
// - software may request new group later
// - low-power crystal also feeds timer one
// - reset loads current and new group
`timescale 1ns/1ps
`include "oss_consts.vh"

module oss_source_select #(
    parameter CNT_W  = `OSS_STARTUP_W
) (
    // clock and reset (reset covers power-on and brown-out)
    input  wire        core_clk_i,
    input  wire        rst_i,
    // configuration straps
    input  wire [1:0]  group_select_cfg_i,
    input  wire [3:0]  primary_mode_cfg_i,
    // power state and oscillator events (asynchronous)
    input  wire        sleep_i,
    input  wire        osc_tick_i,
    input  wire        pll_phase_locked_i,
    // apb slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    // clock tree controls
    output reg  [1:0]  current_group_status_o,
    output reg  [1:0]  pll_gain_o,
    output reg         sys_clk_enable_o,
    output reg         sys_logic_reset_o,
    output reg         secondary_osc_enable_o,
    output reg         timer1_rtc_clk_enable_o,
    output reg         pll_lock_o,
    // oscillator pins
    output reg  [1:0]  osc_output_pin_func_o,
    output reg         osc_output_pin_iclk_o,
    output reg         osc_input_pin_gpio_o
);

// ----------------------------------------------------------------------
// decode helpers
// ----------------------------------------------------------------------
// true for sources that need the start-up delay
function is_crystal;
    input [1:0] grp;
    input [3:0] mode;
    begin
        if (grp == `OSS_GRP_SEC)
            is_crystal = 1'b1;
        else if (grp == `OSS_GRP_PRI)
            is_crystal = (mode[3:2] == 2'h0) || (mode[3:2] == 2'h1);
        else
            is_crystal = 1'b0;
    end
endfunction

// gain from mode field; only primary uses the pll
function [1:0] gain_of;
    input [1:0] grp;
    input [3:0] mode;
    begin
        gain_of = `OSS_GAIN_NONE;
        if (grp == `OSS_GRP_PRI) begin
            case (mode)
                `OSS_MODE_XTAL_P4,  `OSS_MODE_EXT_P4:  gain_of = `OSS_GAIN_X4;
                `OSS_MODE_XTAL_P8,  `OSS_MODE_EXT_P8:  gain_of = `OSS_GAIN_X8;
                `OSS_MODE_XTAL_P16, `OSS_MODE_EXT_P16: gain_of = `OSS_GAIN_X16;
                default:                               gain_of = `OSS_GAIN_NONE;
            endcase
        end
    end
endfunction

// second pin function depends on mode field alone
function [1:0] pin_func_of;
    input [3:0] mode;
    begin
        case (mode)
            `OSS_MODE_EXT, `OSS_MODE_RC:       pin_func_of = `OSS_PIN_ICLK;
            `OSS_MODE_EXT_IO, `OSS_MODE_RC_IO,
            `OSS_MODE_EXT_P4, `OSS_MODE_EXT_P8,
            `OSS_MODE_EXT_P16:                 pin_func_of = `OSS_PIN_GPIO;
            default:                           pin_func_of = `OSS_PIN_XDRV;
        endcase
    end
endfunction

// ----------------------------------------------------------------------
// input synchronisers
// ----------------------------------------------------------------------
reg  [2:0] sync_a;
reg  [2:0] sync_b;
wire       sleep_s  = sync_b[0];
wire       tick_s   = sync_b[1];
wire       lock_s   = sync_b[2];
reg        tick_d;
reg        sleep_d;

always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        sync_a  <= 3'h0;
        sync_b  <= 3'h0;
        tick_d  <= 1'b0;
        sleep_d <= 1'b0;
    end else begin
        sync_a  <= {pll_phase_locked_i, osc_tick_i, sleep_i};
        sync_b  <= sync_a;
        tick_d  <= tick_s;
        sleep_d <= sleep_s;
    end
end

wire tick_rise = tick_s & ~tick_d;
wire wake      = sleep_d & ~sleep_s;

// ----------------------------------------------------------------------
// configuration capture after reset release
// ----------------------------------------------------------------------
// straps are sampled by a clock edge, never by the async reset itself
reg        cfg_loaded;
reg  [1:0] cur_group;
reg  [1:0] new_group;
reg  [3:0] mode_cfg;
reg        lp_enable;

// ----------------------------------------------------------------------
// apb slave, single-cycle access
// ----------------------------------------------------------------------
wire apb_setup  = psel_i & ~penable_i;
wire apb_access = psel_i & penable_i & pready_o;
wire hit_ctl    = (paddr_i == `OSS_CLKCTL_ADDR);
wire hit_stu    = (paddr_i == `OSS_STARTUP_ADDR);
wire ctl_wr     = apb_access & pwrite_i & hit_ctl;

// switch request: a new group while the current one differs
wire switch_go  = cfg_loaded && (new_group != cur_group) && !ctl_wr;
// leaving low-power crystal for a primary crystal restarts the delay
wire back_to_xt = switch_go && (cur_group == `OSS_GRP_SEC)
                  && is_crystal(new_group, mode_cfg);

always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        cfg_loaded <= 1'b0;
        cur_group  <= `OSS_GRP_FRC;
        new_group  <= `OSS_GRP_FRC;
        mode_cfg   <= 4'h0;
        lp_enable  <= `OSS_LPEN_RST;
    end else if (!cfg_loaded) begin
        cfg_loaded <= 1'b1;
        cur_group  <= group_select_cfg_i;
        new_group  <= group_select_cfg_i;
        mode_cfg   <= primary_mode_cfg_i;
    end else begin
        if (ctl_wr) begin
            new_group <= pwdata_i[`OSS_NEW_LSB+1:`OSS_NEW_LSB];
            lp_enable <= pwdata_i[`OSS_LPEN_BIT];
        end
        // group switch takes effect one cycle after the request
        if (switch_go) begin
            cur_group <= new_group;
        end
    end
end

// ----------------------------------------------------------------------
// start-up delay timer
// ----------------------------------------------------------------------
wire restart = !cfg_loaded || wake || back_to_xt;
wire [CNT_W-1:0] st_count;
wire             st_done;

oss_startup_timer #(
    .CNT_W     (CNT_W)
) u_startup (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .restart_i  (restart),
    .osc_tick_i (tick_rise),
    .done_o     (st_done),
    .count_o    (st_count)
);

// crystal sources wait for the timer, others are ready at once
wire need_delay = is_crystal(cur_group, mode_cfg);
wire clk_ready  = cfg_loaded && !restart && (st_done || !need_delay);
// low-power crystal drives the system only while enabled
wire lp_ok      = (cur_group != `OSS_GRP_SEC) || lp_enable;

// ----------------------------------------------------------------------
// registered outputs
// ----------------------------------------------------------------------
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        current_group_status_o  <= `OSS_GRP_FRC;
        pll_gain_o              <= `OSS_GAIN_NONE;
        sys_clk_enable_o        <= 1'b0;
        sys_logic_reset_o       <= 1'b1;
        secondary_osc_enable_o  <= 1'b0;
        timer1_rtc_clk_enable_o <= 1'b0;
        pll_lock_o              <= 1'b0;
        osc_output_pin_func_o   <= `OSS_PIN_XDRV;
        osc_output_pin_iclk_o   <= 1'b0;
        osc_input_pin_gpio_o    <= 1'b0;
    end else begin
        current_group_status_o  <= cur_group;
        pll_gain_o              <= gain_of(cur_group, mode_cfg);
        sys_clk_enable_o        <= clk_ready && lp_ok;
        sys_logic_reset_o       <= !(clk_ready && lp_ok);
        // runs through sleep too: sleep is not a term here
        secondary_osc_enable_o  <= lp_enable;
        // rtc path stays open alongside system-clock use
        timer1_rtc_clk_enable_o <= lp_enable;
        pll_lock_o              <= lock_s;
        osc_output_pin_func_o   <= pin_func_of(mode_cfg);
        osc_output_pin_iclk_o   <= (pin_func_of(mode_cfg) == `OSS_PIN_ICLK);
        osc_input_pin_gpio_o    <= 1'b0;
    end
end

// ----------------------------------------------------------------------
// apb response: ready in access, data registered on setup
// ----------------------------------------------------------------------
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        prdata_o  <= 32'h0000_0000;
        pready_o  <= 1'b0;
        pslverr_o <= 1'b0;
    end else begin
        pready_o  <= apb_setup;
        pslverr_o <= apb_setup & ~(hit_ctl | hit_stu);
        prdata_o  <= 32'h0000_0000;
        if (apb_setup && !pwrite_i && hit_ctl) begin
            prdata_o[`OSS_CUR_LSB+1:`OSS_CUR_LSB]   <= cur_group;
            prdata_o[`OSS_NEW_LSB+1:`OSS_NEW_LSB]   <= new_group;
            prdata_o[`OSS_LOCK_BIT]                 <= lock_s;
            prdata_o[`OSS_LPEN_BIT]                 <= lp_enable;
            prdata_o[`OSS_STARTED_BIT]              <= st_done;
            prdata_o[`OSS_SYSCLK_BIT]               <= sys_clk_enable_o;
            prdata_o[`OSS_GAIN_LSB+1:`OSS_GAIN_LSB] <= gain_of(cur_group, mode_cfg);
        end else if (apb_setup && !pwrite_i && hit_stu) begin
            prdata_o[CNT_W-1:0] <= st_count;
        end
    end
end

endmodule // oss_source_select

// file: inc/oss_consts.vh
`ifndef OSS_CONSTS_VH
`define OSS_CONSTS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OSS_CLKCTL_ADDR      12'h000
`define OSS_STARTUP_ADDR     12'h004

// ----------------------------------------------------------------------
// clock control register fields
// ----------------------------------------------------------------------
`define OSS_CUR_LSB          0
`define OSS_NEW_LSB          4
`define OSS_LOCK_BIT         8
`define OSS_LPEN_BIT         9
`define OSS_STARTED_BIT      10
`define OSS_SYSCLK_BIT       11
`define OSS_GAIN_LSB         12

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define OSS_LPEN_RST         1'b0

// ----------------------------------------------------------------------
// group and mode codes
// ----------------------------------------------------------------------
`define OSS_GRP_SEC          2'h0
`define OSS_GRP_FRC          2'h1
`define OSS_GRP_SLOW_INTERNAL_RC         2'h2
`define OSS_GRP_PRI          2'h3

`define OSS_MODE_EXT         4'hB
`define OSS_MODE_EXT_IO      4'hC
`define OSS_MODE_EXT_P4      4'hD
`define OSS_MODE_EXT_P8      4'hE
`define OSS_MODE_EXT_P16     4'hF
`define OSS_MODE_RC          4'h9
`define OSS_MODE_RC_IO       4'h8
`define OSS_MODE_XTAL        4'h4
`define OSS_MODE_XTAL_P4     4'h5
`define OSS_MODE_XTAL_P8     4'h6
`define OSS_MODE_XTAL_P16    4'h7

// pll gain codes: 0 none, 1 x4, 2 x8, 3 x16
`define OSS_GAIN_NONE        2'h0
`define OSS_GAIN_X4          2'h1
`define OSS_GAIN_X8          2'h2
`define OSS_GAIN_X16         2'h3

// osc output pin function
`define OSS_PIN_ICLK         2'h0
`define OSS_PIN_GPIO         2'h1
`define OSS_PIN_XDRV         2'h2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define OSS_STARTUP_CYCLES   1024
`define OSS_STARTUP_W        10

`endif

// file: hw/oss_startup_timer.v
`timescale 1ns/1ps
`include "oss_consts.vh"

module oss_startup_timer #(
    parameter CNT_W  = `OSS_STARTUP_W
) (
    // clock and reset
    input  wire             core_clk_i,
    input  wire             rst_i,
    // control
    input  wire             restart_i,
    input  wire             osc_tick_i,
    // status
    output reg              done_o,
    output reg  [CNT_W-1:0] count_o
);

// ----------------------------------------------------------------------
// ten-bit counter of oscillator cycles; done after full wrap
// ----------------------------------------------------------------------
// done sets when the counter wraps, i.e. after 2**CNT_W ticks
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        count_o <= {CNT_W{1'b0}};
        done_o  <= 1'b0;
    end else if (restart_i) begin
        count_o <= {CNT_W{1'b0}};
        done_o  <= 1'b0;
    end else if (osc_tick_i && !done_o) begin
        count_o <= count_o + 1'b1;
        if (&count_o) begin
            done_o <= 1'b1;
        end
    end
end

endmodule // oss_startup_timer

// file: verif/oss_osc_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// oscillator and pll stand-in
// ----------------------------------------
module oss_osc_model #(
    parameter HALF_NS = 110 // 4.5 MHz keeps even x16 under the core limit
) (
    // bench control
    input  wire logic run_i,
    input  wire logic lock_req_i,
    // oscillator side
    output logic      tick_o,
    output logic      locked_o
);
    // a stopped crystal does not swing, so no stray counts before start-up
    initial tick_o = 1'b0;
    always #(HALF_NS) tick_o = run_i ? ~tick_o : 1'b0;
    // loop needs time to settle before lock shows
    initial locked_o = 1'b0;
    always @(lock_req_i) locked_o <= #300 lock_req_i;
endmodule // oss_osc_model

// file: verif/oss_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checks for the source selector
// ----------------------------------------
module oss_checker (
    // clock and reset
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    // inputs
    input wire logic        pll_phase_locked_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    // outputs
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [1:0]  current_group_status_o,
    input wire logic [1:0]  pll_gain_o,
    input wire logic        sys_clk_enable_o,
    input wire logic        sys_logic_reset_o,
    input wire logic        secondary_osc_enable_o,
    input wire logic        timer1_rtc_clk_enable_o,
    input wire logic        pll_lock_o,
    input wire logic [1:0]  osc_output_pin_func_o,
    input wire logic        osc_output_pin_iclk_o,
    input wire logic        osc_input_pin_gpio_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    a_setup_gets_ready: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access");
    a_unmapped_err: assert property (pready_o && paddr_i != 12'h000 && paddr_i != 12'h004 |-> pslverr_o)
        else $error("unmapped access not refused");
    a_lock_rises: assert property (pll_phase_locked_i [*5] |-> pll_lock_o)
        else $error("lock not shown");
    a_lock_falls: assert property (!pll_phase_locked_i [*5] |-> !pll_lock_o)
        else $error("lock not withdrawn");
    a_lock_mirror: assert property (pready_o && !pwrite_i && paddr_i == 12'h000 |-> prdata_o[8] == pll_lock_o)
        else $error("lock bit differs");
    a_logic_held: assert property (sys_logic_reset_o == !sys_clk_enable_o)
        else $error("logic reset not inverse of clock");
    a_gain_primary: assert property (pll_gain_o != 2'h0 |-> current_group_status_o == 2'h3)
        else $error("pll gain outside primary");
    a_iclk_func: assert property (osc_output_pin_iclk_o == (osc_output_pin_func_o == 2'h0))
        else $error("clock out pin mismatch");
    a_input_not_io: assert property (!osc_input_pin_gpio_o)
        else $error("input pin made general io");
    a_rtc_shared: assert property (secondary_osc_enable_o == timer1_rtc_clk_enable_o)
        else $error("timer clock not shared");
endmodule // oss_checker

bind oss_source_select oss_checker u_chk (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .pll_phase_locked_i(pll_phase_locked_i), .psel_i(psel_i),
    .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .current_group_status_o(current_group_status_o), .pll_gain_o(pll_gain_o), .sys_clk_enable_o(sys_clk_enable_o),
    .sys_logic_reset_o(sys_logic_reset_o), .secondary_osc_enable_o(secondary_osc_enable_o),
    .timer1_rtc_clk_enable_o(timer1_rtc_clk_enable_o), .pll_lock_o(pll_lock_o),
    .osc_output_pin_func_o(osc_output_pin_func_o), .osc_output_pin_iclk_o(osc_output_pin_iclk_o),
    .pwrite_i(pwrite_i), .osc_input_pin_gpio_o(osc_input_pin_gpio_o));

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic core_clk_i = 1'b0, rst_i = 1'b1, sleep_i = 1'b0, tick, locked, osc_run = 1'b0, lock_req = 1'b0;
    logic [1:0] grp = 2'h3, g, func, gain, cur;
    logic [3:0] mode = 4'h4, m;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, perr, sclk, slrst, sen, ten, plock, iclk, igp;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, d;
    logic err, xt;
    int mismatches = 0, n_checks = 0, s;
    // 16-tick start-up keeps each crystal case short
    oss_source_select #(.CNT_W(4)) DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .group_select_cfg_i(grp),
        .primary_mode_cfg_i(mode), .sleep_i(sleep_i), .osc_tick_i(tick), .pll_phase_locked_i(locked),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .current_group_status_o(cur),
        .pll_gain_o(gain), .sys_clk_enable_o(sclk), .sys_logic_reset_o(slrst), .secondary_osc_enable_o(sen),
        .timer1_rtc_clk_enable_o(ten), .pll_lock_o(plock), .osc_output_pin_func_o(func),
        .osc_output_pin_iclk_o(iclk), .osc_input_pin_gpio_o(igp));
    oss_osc_model u_osc (.run_i(osc_run), .lock_req_i(lock_req), .tick_o(tick), .locked_o(locked));
    always #25 core_clk_i = ~core_clk_i;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk_i);
    endtask
    // apb master: one setup cycle, hold the access until ready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
        int n;
        @(posedge core_clk_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= dat;
        @(posedge core_clk_i);
        penable <= 1'b1;
        n = 0;
        // ready, read data and error are taken at the edge that ends the access
        do begin @(posedge core_clk_i); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = perr;
        if (n >= 20) mismatches++;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wait_en(input int lim);
        int n;
        n = 0;
        while (sclk !== 1'b1 && n < lim) begin @(negedge core_clk_i); n++; end
    endtask
    task automatic do_reset(input logic [1:0] gg, input logic [3:0] mm);
        @(posedge core_clk_i);
        rst_i <= 1'b1; grp <= gg; mode <= mm; osc_run = 1'b0;
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        cyc(4);
    endtask
    function automatic logic [1:0] f_func(input logic [3:0] mm);
        if (mm < 4'h8) return 2'h2;
        if (mm == 4'hB || mm == 4'h9) return 2'h0;
        return 2'h1;
    endfunction
    function automatic logic [1:0] f_gain(input logic [1:0] gg, input logic [3:0] mm);
        if (gg != 2'h3) return 2'h0;
        if (mm >= 4'hD) return 2'(mm - 4'hC);
        if (mm >= 4'h5 && mm <= 4'h7) return 2'(mm - 4'h4);
        return 2'h0;
    endfunction
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------------------------------------
    // every primary mode, then the other groups
    // ----------------------------------------
    initial begin
        s = $urandom(1854);
        for (int i = 0; i < 19; i++) begin
            if (i == 10) continue; // code 1010 selects nothing
            g = (i < 16) ? 2'h3 : 2'(i - 16);
            m = (i < 16) ? 4'(i) : ((i == 16) ? 4'($urandom % 8) : 4'($urandom));
            xt = (g == 2'h0) || (g == 2'h3 && m < 4'h8);
            do_reset(g, m);
            check("group", cur, g);
            if (g == 2'h3) check("pin_func", func, f_func(m));
            check("gain", gain, f_gain(g, m));
            apb(1'b0, 12'h000, 32'h0);
            check("ctl_groups", {rd[5:4], rd[1:0]}, {g, g});
            check("ctl_lock", rd[8], 1'b0);
            if (xt) begin
                osc_run = (g == 2'h0); // secondary swings but stays unused until enabled
                cyc(40);
                check("held", sclk, 1'b0);
                if (g == 2'h0) begin
                    apb(1'b1, 12'h000, 32'h200);
                    cyc(2);
                    check("lp_on", sen, 1'b1);
                end
                osc_run = 1'b1;
                wait_en(600);
                check("released", sclk, 1'b1);
                apb(1'b0, 12'h000, 32'h0);
                check("ctl_status", rd[13:10], {f_gain(g, m), 2'b11});
            end else begin
                wait_en(5);
                check("no_delay", sclk, 1'b1);
            end
            if (g == 2'h3 && m == 4'h4) begin
                @(posedge core_clk_i) sleep_i <= 1'b1;
                cyc(5);
                @(posedge core_clk_i) sleep_i <= 1'b0;
                cyc(6);
                check("wake_hold", sclk, 1'b0);
                wait_en(600);
                check("wake_release", sclk, 1'b1);
                lock_req = 1'b1;
                cyc(12);
                check("lock_up", plock, 1'b1);
                apb(1'b1, 12'h000, 32'h30);
                apb(1'b0, 12'h000, 32'h0);
                check("lock_ro", rd[8], 1'b1);
                lock_req = 1'b0;
                cyc(12);
                check("lock_down", plock, 1'b0);
            end
            if (g == 2'h0) begin
                apb(1'b1, 12'h000, 32'h230);
                cyc(3);
                check("to_primary", cur, 2'h3);
                check("restart", sclk, 1'b0);
                wait_en(600);
                check("restart_done", sclk, 1'b1);
            end
            if (g == 2'h1 || g == 2'h2) begin
                d = $urandom;
                d[5:4] = g;
                apb(1'b1, 12'h000, d);
                cyc(2);
                check("lp_en", sen, d[9]);
                check("rtc_en", ten, d[9]);
                apb(1'b0, 12'h000, 32'h0);
                check("ro_bits", {rd[8], rd[1:0]}, {1'b0, g});
                apb(1'b0, 12'h008, 32'h0);
                check("unmapped_err", err, 1'b1);
                check("unmapped_data", rd, 32'h0);
            end
        end
        summarize;
    end
    // watchdog well beyond the expected few thousand cycles
    initial begin
        repeat (40000) @(posedge core_clk_i);
        mismatches++;
        summarize;
    end
endmodule // testbench
